/* rtl/mcs_top.sv */
/*
 * Modulator carrier select: two carrier control registers, source
 * selection, inversion, pin release and edge-synchronised switching.
 * Assumes an APB master on SYS_CLK_IN and carrier inputs synchronous to it.
 */
// Overview of operation
// - Output follows high carrier when modulation is one, low carrier when zero.
// - High selector: 0 ground, 1 pin one, 2 pin two, 3 refclk, 4 PWM.
// - Low selector: 0 ground, 1 pin one, 3 refclk, 4 PWM; others nothing.
// - High pin-release bit set stops selected high source driving its pin.
// - Low pin-release bit set disconnects selected low source from its pin.
// - High invert bit set inverts the selected high carrier.
// - Low invert bit set inverts the selected low carrier.
// - High sync set: switch high to low waits for high falling edge.
// - Low sync set: switch low to high waits for low falling edge.
// - Bit four of both carrier registers reads zero and ignores writes.
// - Carrier control bits keep their values across all but power-on reset.
`timescale 1ns/1ps
`default_nettype none
module mcs_top
   import mcs_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_IN,
   input  wire logic        CE_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        CARRIER_PIN_ONE_IN,
   input  wire logic        CARRIER_PIN_TWO_IN,
   input  wire logic        REFERENCE_CLOCK_IN,
   input  wire logic        PWM_IN,
   input  wire logic        MODULATION_IN,
   output logic             MOD_OUT,
   output logic [3:0]       HIGH_PIN_RELEASE_OUT,
   output logic [3:0]       LOW_PIN_RELEASE_OUT
);
   logic [7:0] high_ctrl_r;
   logic [7:0] low_ctrl_r;
   logic [1:0] mod_ctrl_r;
   mcs_state_t state_r;
   mcs_state_t state_nxt;
   logic       mod_sel;
   logic       high_car;
   logic       low_car;
   logic       high_fall;
   logic       low_fall;
   logic       acc;
   logic       wr;
   logic       hit;
   logic       out_nxt;
   logic [1:0] cfg_seen_r;
   logic       cfg_ok;

   // Decoded one-hot pin release for one carrier register
   function automatic logic [3:0] rel_map(input logic [7:0] ctrl, input logic pin2_ok);
      logic [3:0] m;
      m = 4'h0;
      if (ctrl[MCS_BIT_PIN_RELEASE]) begin
         case (ctrl[MCS_SEL_MSB:0])
            MCS_SEL_PIN1:   m = 4'h1;
            MCS_SEL_PIN2:   m = pin2_ok ? 4'h2 : 4'h0;
            MCS_SEL_REFCLK: m = 4'h4;
            MCS_SEL_PWM:    m = 4'h8;
            default:        m = 4'h0;
         endcase
      end
      return m;
   endfunction

   // Address hit for a mapped register
   function automatic logic mapped(input logic [7:0] a);
      return (a == MCS_OFS_HIGH_CTRL) || (a == MCS_OFS_LOW_CTRL) ||
             (a == MCS_OFS_MOD_CTRL)  || (a == MCS_OFS_STATUS);
   endfunction

   assign acc = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
   assign wr  = acc & PWRITE_IN;
   assign hit = mapped(PADDR_IN);

   // Carrier control registers; only power-on reset would clear them, so a
   // bus reset leaves them intact
   always_ff @(posedge SYS_CLK_IN) begin
      if (CE_IN && wr) begin
         if (PADDR_IN == MCS_OFS_HIGH_CTRL) begin
            high_ctrl_r <= PWDATA_IN[7:0] & MCS_CAR_WMASK;
         end
         if (PADDR_IN == MCS_OFS_LOW_CTRL) begin
            low_ctrl_r <= PWDATA_IN[7:0] & MCS_CAR_WMASK;
         end
      end
   end

   // Modulation source control
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         mod_ctrl_r <= MCS_MOD_RESET;
      end else if (CE_IN && wr && PADDR_IN == MCS_OFS_MOD_CTRL) begin
         mod_ctrl_r <= PWDATA_IN[1:0];
      end
   end

   // Both carrier registers written since the last reset; they power up
   // unknown, so checks on the mixed output wait until software has set them
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cfg_seen_r <= 2'h0;
      end else if (CE_IN && wr) begin
         if (PADDR_IN == MCS_OFS_HIGH_CTRL) begin
            cfg_seen_r[0] <= 1'b1;
         end
         if (PADDR_IN == MCS_OFS_LOW_CTRL) begin
            cfg_seen_r[1] <= 1'b1;
         end
      end
   end

   assign cfg_ok = &cfg_seen_r;

   // APB answer: one wait state, so PREADY pulses in the second access cycle
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
      end else if (CE_IN) begin
         PREADY_OUT  <= acc;
         PSLVERR_OUT <= acc & ~hit;
         PRDATA_OUT  <= 32'h0000_0000;
         if (acc && !PWRITE_IN) begin
            case (PADDR_IN)
               MCS_OFS_HIGH_CTRL: PRDATA_OUT <= {24'h0, high_ctrl_r & MCS_CAR_WMASK};
               MCS_OFS_LOW_CTRL:  PRDATA_OUT <= {24'h0, low_ctrl_r & MCS_CAR_WMASK};
               MCS_OFS_MOD_CTRL:  PRDATA_OUT <= {30'h0, mod_ctrl_r};
               MCS_OFS_STATUS:    PRDATA_OUT <= {30'h0, state_r, MOD_OUT};
               default:           PRDATA_OUT <= 32'h0000_0000;
            endcase
         end
      end
   end

   // High carrier path
   mcs_carrier_path #(.HAS_PIN2(1'b1)) u_high (
      .clk_in      (SYS_CLK_IN),
      .rst_in      (RST_IN),
      .ce_in       (CE_IN),
      .sel_in      (high_ctrl_r[MCS_SEL_MSB:0]),
      .invert_in   (high_ctrl_r[MCS_BIT_INVERT]),
      .pin1_in     (CARRIER_PIN_ONE_IN),
      .pin2_in     (CARRIER_PIN_TWO_IN),
      .refclk_in   (REFERENCE_CLOCK_IN),
      .pwm_in      (PWM_IN),
      .carrier_out (high_car),
      .fall_out    (high_fall)
   );

   // Low carrier path; pin two is not a low source
   mcs_carrier_path #(.HAS_PIN2(1'b0)) u_low (
      .clk_in      (SYS_CLK_IN),
      .rst_in      (RST_IN),
      .ce_in       (CE_IN),
      .sel_in      (low_ctrl_r[MCS_SEL_MSB:0]),
      .invert_in   (low_ctrl_r[MCS_BIT_INVERT]),
      .pin1_in     (CARRIER_PIN_ONE_IN),
      .pin2_in     (CARRIER_PIN_TWO_IN),
      .refclk_in   (REFERENCE_CLOCK_IN),
      .pwm_in      (PWM_IN),
      .carrier_out (low_car),
      .fall_out    (low_fall)
   );

   // Modulation value comes from software or from the input pin
   assign mod_sel = mod_ctrl_r[MCS_BIT_MOD_SRC_SW] ? mod_ctrl_r[MCS_BIT_MOD_VALUE]
                                                   : MODULATION_IN;

   // Carrier switch decision; a sync wait holds the old carrier until its
   // falling edge, which avoids narrowed pulses at the cost of latency
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         MCS_ST_HIGH: begin
            if (!mod_sel && (!high_ctrl_r[MCS_BIT_SYNC] || high_fall)) begin
               state_nxt = MCS_ST_LOW;
            end
         end
         MCS_ST_LOW: begin
            if (mod_sel && (!low_ctrl_r[MCS_BIT_SYNC] || low_fall)) begin
               state_nxt = MCS_ST_HIGH;
            end
         end
         default: state_nxt = MCS_ST_LOW;
      endcase
   end

   assign out_nxt = (state_nxt == MCS_ST_HIGH) ? high_car : low_car;

   // Current carrier and registered mixed output
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_r <= MCS_ST_LOW;
         MOD_OUT <= 1'b0;
      end else if (CE_IN) begin
         state_r <= state_nxt;
         MOD_OUT <= out_nxt;
      end
   end

   // Registered pin release levels toward carrier peripherals, held while the release bit is set
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         HIGH_PIN_RELEASE_OUT <= 4'h0;
         LOW_PIN_RELEASE_OUT  <= 4'h0;
      end else if (CE_IN) begin
         HIGH_PIN_RELEASE_OUT <= rel_map(high_ctrl_r, 1'b1);
         LOW_PIN_RELEASE_OUT  <= rel_map(low_ctrl_r, 1'b0);
      end
   end

   // Assertions
   property p_mix_high;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && state_nxt == MCS_ST_HIGH) |=> (MOD_OUT == $past(high_car));
   endproperty
   a_mix_high: assert property (p_mix_high) else $error("high carrier not passed");

   property p_mix_low;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && state_nxt == MCS_ST_LOW) |=> (MOD_OUT == $past(low_car));
   endproperty
   a_mix_low: assert property (p_mix_low) else $error("low carrier not passed");

   property p_high_sel;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (high_ctrl_r[3:0] == MCS_SEL_PIN2) |->
         (high_car == (CARRIER_PIN_TWO_IN ^ high_ctrl_r[MCS_BIT_INVERT]));
   endproperty
   a_high_sel: assert property (p_high_sel) else $error("high pin two select wrong");

   property p_low_sel;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (low_ctrl_r[3:0] == MCS_SEL_PIN2 || low_ctrl_r[3:0] > MCS_SEL_PWM) |->
         (low_car == low_ctrl_r[MCS_BIT_INVERT]);
   endproperty
   a_low_sel: assert property (p_low_sel) else $error("low reserved code connected");

   property p_high_rel;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && !high_ctrl_r[MCS_BIT_PIN_RELEASE]) |=>
         (HIGH_PIN_RELEASE_OUT == 4'h0);
   endproperty
   a_high_rel: assert property (p_high_rel) else $error("high pin released wrongly");

   property p_low_rel;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && low_ctrl_r[MCS_BIT_PIN_RELEASE] && low_ctrl_r[3:0] == MCS_SEL_PWM)
         |=> LOW_PIN_RELEASE_OUT[3];
   endproperty
   a_low_rel: assert property (p_low_rel) else $error("low pin not released");

   property p_high_sync;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && state_r == MCS_ST_HIGH && high_ctrl_r[MCS_BIT_SYNC] && !high_fall)
         |=> (state_r == MCS_ST_HIGH);
   endproperty
   a_high_sync: assert property (p_high_sync) else $error("left high without edge");

   property p_low_sync;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && state_r == MCS_ST_LOW && !low_ctrl_r[MCS_BIT_SYNC] && mod_sel)
         |=> (state_r == MCS_ST_HIGH);
   endproperty
   a_low_sync: assert property (p_low_sync) else $error("unsynced switch late");

   property p_bit4;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && acc && !PWRITE_IN && PADDR_IN == MCS_OFS_LOW_CTRL) |=> !PRDATA_OUT[4];
   endproperty
   a_bit4: assert property (p_bit4) else $error("bit four reads one");

   property p_high_pwm;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (high_ctrl_r[MCS_SEL_MSB:0] == MCS_SEL_PWM) |->
         (high_car == (PWM_IN ^ high_ctrl_r[MCS_BIT_INVERT]));
   endproperty
   a_high_pwm: assert property (p_high_pwm) else $error("high PWM select wrong");

   // A grounded source shows the invert bit alone, so polarity is seen directly
   property p_high_inv;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (high_ctrl_r[MCS_SEL_MSB:0] == MCS_SEL_GROUND) |->
         (high_car == high_ctrl_r[MCS_BIT_INVERT]);
   endproperty
   a_high_inv: assert property (p_high_inv) else $error("high polarity wrong");

   property p_low_inv;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (low_ctrl_r[MCS_SEL_MSB:0] == MCS_SEL_REFCLK) |->
         (low_car == (REFERENCE_CLOCK_IN ^ low_ctrl_r[MCS_BIT_INVERT]));
   endproperty
   a_low_inv: assert property (p_low_inv) else $error("low polarity wrong");

   property p_high_rel_set;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && high_ctrl_r[MCS_BIT_PIN_RELEASE] &&
       high_ctrl_r[MCS_SEL_MSB:0] == MCS_SEL_PIN2) |=> HIGH_PIN_RELEASE_OUT[1];
   endproperty
   a_high_rel_set: assert property (p_high_rel_set) else $error("pin two not released");

   // Pin two is no low source, so the low side never releases anything for it
   property p_low_rel_pin2;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && cfg_ok && low_ctrl_r[MCS_SEL_MSB:0] == MCS_SEL_PIN2) |=>
         (LOW_PIN_RELEASE_OUT == 4'h0);
   endproperty
   a_low_rel_pin2: assert property (p_low_rel_pin2) else $error("low released pin two");

   // Every access cycle with CE_IN high is answered one clock later, with an error if unmapped
   property p_apb_ready;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (CE_IN && acc) |=> (PREADY_OUT && (PSLVERR_OUT != $past(hit)));
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("bus answer missing");

   // Leaving a carrier under sync takes a pending request and its edge in the same cycle
   sequence s_high_leave_req;
      CE_IN && cfg_ok && state_r == MCS_ST_HIGH && high_ctrl_r[MCS_BIT_SYNC] && !mod_sel;
   endsequence

   sequence s_high_edge_seen;
      high_fall;
   endsequence

   property p_high_sync_take;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (s_high_leave_req ##0 s_high_edge_seen) |=> (state_r == MCS_ST_LOW);
   endproperty
   a_high_sync_take: assert property (p_high_sync_take) else $error("high edge not taken");

   sequence s_low_leave_req;
      CE_IN && cfg_ok && state_r == MCS_ST_LOW && low_ctrl_r[MCS_BIT_SYNC] && mod_sel;
   endsequence

   sequence s_low_edge_seen;
      low_fall;
   endsequence

   property p_low_sync_take;
      @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (s_low_leave_req ##0 s_low_edge_seen) |=> (state_r == MCS_ST_HIGH);
   endproperty
   a_low_sync_take: assert property (p_low_sync_take) else $error("low edge not taken");
endmodule
`default_nettype wire

/* rtl/mcs_pkg.sv */
/*
 * Package for the modulator carrier-select block: register offsets, field
 * positions, selector codes and reset values.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package mcs_pkg;
   // Register byte offsets on the APB bus
   localparam logic [7:0] MCS_OFS_HIGH_CTRL = 8'h00;
   localparam logic [7:0] MCS_OFS_LOW_CTRL  = 8'h04;
   localparam logic [7:0] MCS_OFS_MOD_CTRL  = 8'h08;
   localparam logic [7:0] MCS_OFS_STATUS    = 8'h0C;

   // Carrier control field positions
   localparam int MCS_BIT_PIN_RELEASE = 7;
   localparam int MCS_BIT_INVERT      = 6;
   localparam int MCS_BIT_SYNC        = 5;
   localparam int MCS_BIT_UNUSED      = 4;
   localparam int MCS_SEL_MSB         = 3;

   // Modulation control field positions
   localparam int MCS_BIT_MOD_VALUE   = 0;
   localparam int MCS_BIT_MOD_SRC_SW  = 1;

   // Writable mask of a carrier control register
   localparam logic [7:0] MCS_CAR_WMASK = 8'hEF;
   localparam logic [7:0] MCS_CAR_RESET = 8'h00;
   localparam logic [1:0] MCS_MOD_RESET = 2'h0;

   // Selector codes
   localparam logic [3:0] MCS_SEL_GROUND = 4'h0;
   localparam logic [3:0] MCS_SEL_PIN1   = 4'h1;
   localparam logic [3:0] MCS_SEL_PIN2   = 4'h2;
   localparam logic [3:0] MCS_SEL_REFCLK = 4'h3;
   localparam logic [3:0] MCS_SEL_PWM    = 4'h4;

   // Which carrier is being passed
   typedef enum logic [0:0] {
      MCS_ST_LOW  = 1'b0,
      MCS_ST_HIGH = 1'b1
   } mcs_state_t;
endpackage

/* rtl/mcs_carrier_path.sv */
/*
 * One carrier path: source selection, optional inversion and a registered
 * copy used for falling-edge detection.
 * Assumes carrier sources are synchronous to SYS clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mcs_carrier_path
   import mcs_pkg::*;
#(
   parameter bit HAS_PIN2 = 1'b1
) (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic [3:0] sel_in,
   input  wire logic       invert_in,
   input  wire logic       pin1_in,
   input  wire logic       pin2_in,
   input  wire logic       refclk_in,
   input  wire logic       pwm_in,
   output logic            carrier_out,
   output logic            fall_out
);
   logic raw;
   logic prev_r;

   // Source multiplexer; reserved codes connect nothing and give zero
   always_comb begin
      case (sel_in)
         MCS_SEL_GROUND: raw = 1'b0;
         MCS_SEL_PIN1:   raw = pin1_in;
         MCS_SEL_PIN2:   raw = HAS_PIN2 ? pin2_in : 1'b0;
         MCS_SEL_REFCLK: raw = refclk_in;
         MCS_SEL_PWM:    raw = pwm_in;
         default:        raw = 1'b0;
      endcase
   end

   // Inversion is applied before edge detection
   assign carrier_out = raw ^ invert_in;

   // Previous value of the conditioned carrier
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_r <= 1'b0;
      end else if (ce_in) begin
         prev_r <= carrier_out;
      end
   end

   assign fall_out = prev_r & ~carrier_out;
endmodule
`default_nettype wire

/* sim/mcs_carrier_model.sv */
/*
 * Carrier source model: the two input pins, the reference clock and the
 * PWM output as the block sees them.
 * Assumes the bench sets each source level; sources lag it by one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mcs_carrier_model (
   input  wire logic       clk_in,
   input  wire logic [3:0] level_in,
   output logic [3:0]      src_out
);
   // Sources move just after an edge, as synchronous peripherals do
   always_ff @(posedge clk_in) begin
      src_out <= level_in;
   end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
/*
 * Self-checking bench for the carrier-select block: register access,
 * every selector code, pin release and edge-synchronised switching.
 * Assumes the carrier source model and an APB master in this bench.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_top
   import mcs_pkg::*;
;
   logic        clk, rst, ce, psel, pen, pwr, mod, err, pready, pslverr, mod_out;
   logic [7:0]  paddr, hc, lc;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  lvl, src, hrel, lrel;
   int          miscompares, check_count, seed;

   // Sources reach the block through the partner model
   mcs_carrier_model PART (.clk_in(clk), .level_in(lvl), .src_out(src));

   mcs_top DUT (
      .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .CARRIER_PIN_ONE_IN(src[0]), .CARRIER_PIN_TWO_IN(src[1]),
      .REFERENCE_CLOCK_IN(src[2]), .PWM_IN(src[3]), .MODULATION_IN(mod),
      .MOD_OUT(mod_out), .HIGH_PIN_RELEASE_OUT(hrel), .LOW_PIN_RELEASE_OUT(lrel)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Selected carrier after inversion; unconnected codes give ground
   function automatic logic exp_car(logic [7:0] c, logic [3:0] s, logic lo);
      logic v;
      case (c[3:0])
         4'h1: v = s[0];
         4'h2: v = lo ? 1'b0 : s[1];
         4'h3: v = s[2];
         4'h4: v = s[3];
         default: v = 1'b0;
      endcase
      return v ^ c[6];
   endfunction

   // One-hot release of the selected source when the release bit is set
   function automatic logic [3:0] exp_rel(logic [7:0] c, logic lo);
      logic [3:0] r;
      r = 4'h0;
      if (c[7] && c[3:0] >= 4'h1 && c[3:0] <= 4'h4 && !(lo && c[3:0] == 4'h2)) begin
         r[c[1:0] - 2'h1] = 1'b1;
      end
      return r;
   endfunction

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer, entered just after an edge; idles one cycle after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      @(posedge clk);
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   // Switch request held until the current carrier falls, then taken
   task automatic sync_case(logic [7:0] h, logic [7:0] l, logic m, logic p0);
      apb(1'b1, MCS_OFS_HIGH_CTRL, {24'h0, h});
      apb(1'b1, MCS_OFS_LOW_CTRL, {24'h0, l});
      lvl <= {3'b000, p0};
      mod <= m;
      repeat (4) @(posedge clk);
      mod <= ~m;
      repeat (6) @(posedge clk);
      `CHK("held_out", 1'b1, mod_out)
      apb(1'b0, MCS_OFS_STATUS, 32'h0);
      `CHK("held_state", m, rd[1])
      lvl <= {3'b000, ~p0};
      repeat (4) @(posedge clk);
      apb(1'b0, MCS_OFS_STATUS, 32'h0);
      `CHK("switched_state", ~m, rd[1])
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mod = 1'b0;
      lvl = 4'h0;
      seed = $urandom(5);
      do_reset();
      // Values written must survive a later reset
      hc = 8'($urandom());
      lc = ~hc;
      apb(1'b1, MCS_OFS_HIGH_CTRL, {24'hFFFFFF, hc});
      apb(1'b1, MCS_OFS_LOW_CTRL, {24'h0, lc});
      do_reset();
      apb(1'b0, MCS_OFS_HIGH_CTRL, 32'h0);
      `CHK("high_ctrl", {24'h0, hc & MCS_CAR_WMASK}, rd)
      apb(1'b0, MCS_OFS_LOW_CTRL, 32'h0);
      `CHK("low_ctrl", {24'h0, lc & MCS_CAR_WMASK}, rd)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_data", 32'h0, rd)
      $display("test readback done");
      // Every selector code on both carriers, random invert and release
      for (int c = 0; c < 16; c++) begin
         hc = {2'($urandom()), 1'b0, 1'($urandom()), 4'(c)};
         lc = {2'($urandom()), 1'b0, 1'($urandom()), 4'(c)};
         lvl <= 4'($urandom());
         apb(1'b1, MCS_OFS_HIGH_CTRL, {24'h0, hc});
         apb(1'b1, MCS_OFS_LOW_CTRL, {24'h0, lc});
         mod <= 1'b1;
         repeat (4) @(posedge clk);
         `CHK("mod_high", exp_car(hc, lvl, 1'b0), mod_out)
         `CHK("high_release", exp_rel(hc, 1'b0), hrel)
         `CHK("low_release", exp_rel(lc, 1'b1), lrel)
         mod <= 1'b0;
         repeat (4) @(posedge clk);
         `CHK("mod_low", exp_car(lc, lvl, 1'b1), mod_out)
      end
      $display("test selectors done");
      // Enable low freezes the low carrier in spite of a switch request
      ce <= 1'b0;
      mod <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("ce_hold", exp_car(lc, lvl, 1'b1), mod_out)
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("ce_run", exp_car(hc, lvl, 1'b0), mod_out)
      // Software modulation value overrides the low input pin
      mod <= 1'b0;
      apb(1'b1, MCS_OFS_MOD_CTRL, 32'h0000_0003);
      repeat (2) @(posedge clk);
      `CHK("sw_mod", exp_car(hc, lvl, 1'b0), mod_out)
      apb(1'b0, MCS_OFS_MOD_CTRL, 32'h0);
      `CHK("mod_ctrl", 32'h0000_0003, rd)
      apb(1'b1, MCS_OFS_MOD_CTRL, 32'h0);
      $display("test enable done");
      sync_case(8'h21, 8'h03, 1'b1, 1'b1);
      sync_case(8'h03, 8'h61, 1'b0, 1'b0);
      $display("test sync done");
      stop_test();
   end
endmodule
`default_nettype wire
